// [dram_write_precharge_selfrefresh_test.sv]
// Bench: AXI4-Lite master tasks plus a controller model on the memory pins.
// Assumes package, design, checker and model compiled before it.
`timescale 1ns/1ns
module dram_write_precharge_selfrefresh_test;
  logic clk = 0;
  logic rst_n = 0;
  logic termination_control_input = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, mem_dq;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mem_ck, mem_reset_n, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n;
  logic mem_we_n, mem_dqs, data_mask_input;
  logic [2:0] mem_ba;
  logic [15:0] mem_addr, r0;
  int failures = 0, n_tests = 0, cyc = 0;
  dwps_top #(.XS_CK(10'h004), .XSDLL_CK(10'h008)) uut (.*);
  dwps_ctrl_model ctl (.*);
  // 250 MHz system clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  // Hang guard, far beyond the expected run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Register write; address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      rs = s_axi_bresp;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      {rd, rs} = {s_axi_rdata, s_axi_rresp};
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // Stored beat at {bank, column}
  task automatic mchk(input logic [6:0] i, input logic [7:0] e);
    axw(dwps_pkg::REG_PTR, {25'h0, i}, 4'hF);
    axr(dwps_pkg::REG_DATA);
    chk(rd, {24'h0, e});
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    axr(dwps_pkg::REG_STAT);
    chk(rd & m, e);
  endtask
  task automatic t_regs();
    axr(dwps_pkg::REG_CTRL);
    chk(rd, {24'h0, dwps_pkg::WLAT_RST, 2'h0, dwps_pkg::BURST_RST});
    st(32'hFFFFFFFF, 32'h200);
    axr(8'h14);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, dwps_pkg::RESP_SLVERR});
    $display("test regs done");
  endtask
  // Field 00: eight beats whatever the chop bit; masking; two banks
  task automatic t_bl8();
    ctl.cmd(1'b1, dwps_pkg::CMD_ACT, 3'h2, 16'h0);
    ctl.cmd(1'b1, dwps_pkg::CMD_ACT, 3'h5, 16'h0);
    ctl.wr(3'h2, 4'h3, 1'b0, 8, 8'h10, 8'h00);
    ctl.wr(3'h5, 4'h9, 1'b1, 8, 8'h20, 8'h00);
    ctl.wr(3'h2, 4'h0, 1'b1, 8, 8'h30, 8'h04);
    mchk(7'h22, 8'h17);
    mchk(7'h23, 8'h33);
    mchk(7'h58, 8'h27);
    $display("test eight-beat done");
  endtask
  // Field 01 both ways, then fixed chop with chop bit high
  task automatic t_chop();
    axw(dwps_pkg::REG_CTRL, 32'h51, 4'h1);
    ctl.wr(3'h5, 4'h0, 1'b1, 8, 8'h60, 8'h00);
    ctl.wr(3'h5, 4'h2, 1'b0, 4, 8'h40, 8'h00);
    mchk(7'h50, 8'h42);
    mchk(7'h54, 8'h64);
    axw(dwps_pkg::REG_CTRL, 32'h52, 4'h1);
    ctl.wr(3'h5, 4'h4, 1'b1, 4, 8'h70, 8'h00);
    mchk(7'h57, 8'h73);
    mchk(7'h51, 8'h43);
    // Mode-set command on the link puts the field back to eight beats
    ctl.cmd(1'b1, dwps_pkg::CMD_MRS, 3'h0, 16'h0000);
    axr(dwps_pkg::REG_CTRL);
    chk(rd, {24'h0, dwps_pkg::WLAT_RST, 2'h0, dwps_pkg::BF_BL8});
    $display("test chop done");
  endtask
  task automatic t_pre();
    ctl.cmd(1'b1, dwps_pkg::CMD_ACT, 3'h3, 16'h0);
    st(32'hFF, 32'h2C);
    ctl.cmd(1'b1, dwps_pkg::CMD_PRE, 3'h2, 16'h0000);
    st(32'hFF, 32'h28);
    ctl.cmd(1'b1, dwps_pkg::CMD_PRE, 3'h0, 16'h0400);
    st(32'hFF, 32'h00);
    ctl.wr(3'h2, 4'h0, 1'b1, 8, 8'hA0, 8'h00);
    st(32'h10FF, 32'h1000);
    mchk(7'h22, 8'h17);
    axw(dwps_pkg::REG_STAT, 32'h1000, 4'h2);
    st(32'h1000, 32'h0);
    // Termination pin shows in status; back low before self refresh
    @(posedge clk);
    termination_control_input <= 1'b1;
    repeat (3) @(posedge clk);
    st(32'h8000, 32'h8000);
    termination_control_input <= 1'b0;
    $display("test precharge done");
  endtask
  task automatic t_sr();
    axr(dwps_pkg::REG_REFC);
    r0 = rd[15:0];
    ctl.cmd(1'b0, dwps_pkg::CMD_REF, 3'h0, 16'h0);
    axr(dwps_pkg::REG_REFC);
    chk(rd, {16'h0, r0 + 16'h1});
    ctl.cmd(1'b0, dwps_pkg::CMD_ACT, 3'h1, 16'h0);
    st(32'hFFF, 32'h100);
    repeat (90) @(posedge mem_ck);
    axr(dwps_pkg::REG_REFC);
    chk(rd, {16'h0, r0 + 16'h2});
    ctl.cmd(1'b1, 3'h7, 3'h0, 16'h0);
    st(32'hD00, 32'hC00);
    repeat (5) @(posedge mem_ck);
    st(32'hD00, 32'h800);
    repeat (6) @(posedge mem_ck);
    st(32'hF00, 32'h200);
    // Reference settle time kept before the first write after exit
    repeat (512) @(posedge mem_ck);
    ctl.cmd(1'b1, dwps_pkg::CMD_ACT, 3'h1, 16'h0);
    ctl.wr(3'h1, 4'h8, 1'b0, 8, 8'hC0, 8'h00);
    mchk(7'h1A, 8'hC2);
    $display("test self refresh done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_bl8();
    t_chop();
    t_pre();
    t_sr();
    end_of_test();
  end
endmodule

// [dwps_ctrl_model.sv]
// Memory controller model: link clock, commands, strobe and write data.
// Assumes the device oversamples these pins with its own clock.
`timescale 1ns/1ns
module dwps_ctrl_model (
  output logic mem_ck,
  output logic mem_reset_n,
  output logic mem_cke,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [2:0] mem_ba,
  output logic [15:0] mem_addr,
  output logic mem_dqs,
  output logic data_mask_input,
  output logic [7:0] mem_dq
);
  int wl = 5; // Write latency, matches reset value
  // Free-running clock kept stable through self refresh
  initial
  begin
    mem_ck = 0;
    forever #24 mem_ck = ~mem_ck;
  end
  // Idle pins; device reset let go after a few clocks
  initial
  begin
    {mem_reset_n, mem_cs_n, mem_cke, mem_dqs, data_mask_input} = 5'h06;
    {mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr, mem_dq} = 30'h38000000;
    repeat (4) @(posedge mem_ck);
    mem_reset_n <= 1'b1;
  end
  // One command, then no-operation; address bus no longer meaningful
  task automatic cmd(input logic k, input logic [2:0] c, input logic [2:0] b,
                     input logic [15:0] a);
    wait (mem_reset_n === 1'b1);
    @(negedge mem_ck);
    mem_cke <= k;
    {mem_ras_n, mem_cas_n, mem_we_n} <= c;
    mem_ba <= b;
    mem_addr <= a;
    @(negedge mem_ck);
    {mem_ras_n, mem_cas_n, mem_we_n} <= 3'h7;
    mem_ba <= ~b;
    mem_addr <= ~a;
  endtask
  // Write burst: preamble, nb beats each centred on a strobe edge, postamble
  task automatic wr(input logic [2:0] b, input logic [3:0] col, input logic a12,
                    input int nb, input logic [7:0] d0, input logic [7:0] m);
    cmd(1'b1, dwps_pkg::CMD_WR, b, {3'h0, a12, 8'h00, col});
    repeat (wl - 1) @(posedge mem_ck);
    mem_dqs <= 1'b1;
    @(negedge mem_ck);
    mem_dqs <= 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      #12;
      mem_dq <= d0 + 8'(i);
      data_mask_input <= m[i];
      @(mem_ck);
      mem_dqs <= ~mem_dqs;
    end
    @(mem_ck);
    mem_dqs <= 1'b1;
    mem_dq <= ~mem_dq;
    @(posedge mem_ck);
  endtask
endmodule

// [dwps_monitor.sv]
// Checker for the AXI4-Lite side of the block.
// Sees only top-level ports; bound into every dwps_top.
`timescale 1ns/1ns
module dwps_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Read aimed at one of the five mapped words
  logic ar_map;
  assign ar_map = s_axi_araddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response not held");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_arblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while answer pending");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  // Both halves taken together, no answer pending: answer within two cycles
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    (!s_axi_bvalid || s_axi_bready) |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  // A taken address is held until consumed, so the slot reads full next cycle
  property p_bblk;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_bblk: assert property (p_bblk) else $error("second write address taken while one held");
  property p_slv;
    s_axi_arvalid && s_axi_arready && !ar_map |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_slv: assert property (p_slv) else $error("unmapped read not refused");
  property p_okr;
    s_axi_arvalid && s_axi_arready && ar_map |=> s_axi_rresp == 2'h0;
  endproperty
  a_okr: assert property (p_okr) else $error("mapped read refused");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
  c_slv: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind dwps_top dwps_monitor u_mon (.*);

// [dwps_sync.sv]
// Package for the write/precharge/self-refresh block, plus its pin synchroniser.
// Assumes one system clock; every memory-side pin is asynchronous to it.
`timescale 1ns/1ns
package dwps_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_REFC = 8'h08;
  localparam logic [7:0] REG_PTR = 8'h0C;
  localparam logic [7:0] REG_DATA = 8'h10;
  // Control register fields
  localparam int CTRL_BURST_LSB = 0;
  localparam int CTRL_WLAT_LSB = 4;
  // Status register bits
  localparam int ST_SELF_REF = 8;
  localparam int ST_DLL_ON = 9;
  localparam int ST_XS_BUSY = 10;
  localparam int ST_XSDLL_BUSY = 11;
  localparam int ST_ERR_IDLE = 12;
  localparam int ST_ERR_OVF = 13;
  localparam int ST_BURST = 14;
  localparam int ST_ODT = 15;
  // Reset values
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [3:0] WLAT_RST = 4'h5;
  // Burst length field encodings
  localparam logic [1:0] BF_BL8 = 2'h0;
  localparam logic [1:0] BF_OTF = 2'h1;
  localparam logic [1:0] BF_BC4 = 2'h2;
  // Command codes {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  // Address bit positions on the command bus
  localparam int PRE_ALL_BIT = 10;
  localparam int CHOP_SEL_BIT = 12;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing: internal refresh spacing while in self refresh
  localparam int SYS_PERIOD_NS = 4;
  localparam int REF_INTERVAL_NS = 4000;
  localparam int REF_INT_CYC = REF_INTERVAL_NS / SYS_PERIOD_NS;
  // One queued write burst
  typedef struct packed {
    logic v;
    logic [7:0] start;
    logic chop;
    logic [2:0] bank;
    logic [3:0] col;
  } dwps_wslot_t;
endpackage

// Two-flop synchroniser for a bundle of pins
module dwps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Both stages in one state record
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dwps_sync_st_t;
  dwps_sync_st_t st_q;
  dwps_sync_st_t st_d;

  // Next state: first stage feeds only the second
  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// [dwps_top.sv]
// Memory-device command logic: write bursts, precharge, self refresh.
// Assumes all mem_* pins come from a controller on its own clock and are
// oversampled by clk; registers are reached over AXI4-Lite.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns

module dwps_top #(
  parameter logic [9:0] XS_CK = 10'h010,
  parameter logic [9:0] XSDLL_CK = 10'h040
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_ck,
  input wire logic mem_reset_n,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [2:0] mem_ba,
  input wire logic [15:0] mem_addr,
  input wire logic termination_control_input,
  input wire logic mem_dqs,
  input wire logic data_mask_input,
  input wire logic [7:0] mem_dq
);
  // Whole module state
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] burst_length_field;
    logic [3:0] write_latency;
    logic [6:0] mem_ptr;
    logic ck_prev;
    logic dqs_prev;
    logic [7:0] ck_cnt;
    logic [7:0] bank_open;
    logic self_ref;
    logic dll_on;
    logic dll_reset;
    logic [9:0] exit_cnt;
    logic [15:0] ref_cnt;
    logic [9:0] ref_timer;
    logic err_idle;
    logic err_ovf;
    dwps_pkg::dwps_wslot_t cur;
    dwps_pkg::dwps_wslot_t nxt;
    logic cur_run;
    logic [2:0] beat;
  } dwps_st_t;

  dwps_st_t q;
  dwps_st_t n;
  logic [7:0] mem_q [0:127]; // 8 banks x 16 columns of bytes
  logic [36:0] sy; // Synchronised pin bundle
  logic sy_ck, sy_rst_n, sy_cke, sy_cs_n, sy_dqs, sy_dm, sy_odt;
  logic [2:0] sy_cmd, sy_ba;
  logic [15:0] sy_addr;
  logic [7:0] sy_dq;
  logic mem_we; // One byte write this cycle
  logic [6:0] mem_idx;
  logic [7:0] mem_wdata;
  logic [31:0] stat; // Status word
  logic [31:0] rd_word; // Read mux result
  logic [7:0] edge_idx; // Index of the current clock edge
  logic ck_rise, dqs_rise, dqs_fall, start_hit, run_now;
  logic [3:0] beat_col;
  dwps_pkg::dwps_wslot_t slot;

  // All pins pass two flops; same depth keeps them aligned to each other
  dwps_sync #(
    .W(37)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({mem_ck, mem_reset_n, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n,
        mem_ba, mem_addr, termination_control_input, mem_dqs, data_mask_input,
        mem_dq}),
    .q(sy)
  );
  assign {sy_ck, sy_rst_n, sy_cke, sy_cs_n, sy_cmd, sy_ba, sy_addr, sy_odt, sy_dqs,
          sy_dm, sy_dq} = sy;

  // Edge finders on the sampled link clock and strobe
  assign ck_rise = sy_ck & ~q.ck_prev;
  assign dqs_rise = sy_dqs & ~q.dqs_prev;
  assign dqs_fall = ~sy_dqs & q.dqs_prev;
  assign edge_idx = q.ck_cnt + 8'h01;
  // First data edge may coincide with the opening clock edge
  assign start_hit = ck_rise & q.cur.v & ~q.cur_run & (edge_idx == q.cur.start);
  assign run_now = q.cur_run | start_hit;

  // Status word
  always_comb
  begin
    stat = '0;
    stat[7:0] = q.bank_open;
    stat[dwps_pkg::ST_SELF_REF] = q.self_ref;
    stat[dwps_pkg::ST_DLL_ON] = q.dll_on;
    stat[dwps_pkg::ST_XS_BUSY] = ~q.self_ref & (q.exit_cnt < XS_CK);
    stat[dwps_pkg::ST_XSDLL_BUSY] = ~q.self_ref & (q.exit_cnt < XSDLL_CK);
    stat[dwps_pkg::ST_ERR_IDLE] = q.err_idle;
    stat[dwps_pkg::ST_ERR_OVF] = q.err_ovf;
    stat[dwps_pkg::ST_BURST] = q.cur.v;
    stat[dwps_pkg::ST_ODT] = sy_odt;
  end

  // Read data mux
  always_comb
  begin
    rd_word = '0;
    case (s_axi_araddr)
      dwps_pkg::REG_CTRL:
      begin
        rd_word[dwps_pkg::CTRL_BURST_LSB +: 2] = q.burst_length_field;
        rd_word[dwps_pkg::CTRL_WLAT_LSB +: 4] = q.write_latency;
      end
      dwps_pkg::REG_STAT: rd_word = stat;
      dwps_pkg::REG_REFC: rd_word[15:0] = q.ref_cnt;
      dwps_pkg::REG_PTR: rd_word[6:0] = q.mem_ptr;
      dwps_pkg::REG_DATA: rd_word[7:0] = mem_q[q.mem_ptr];
      default: rd_word = '0; // Unmapped reads zero
    endcase
  end

  // Beat column: wraps inside a block of four or eight
  always_comb
  begin
    if (q.cur.chop)
    begin
      beat_col = {q.cur.col[3:2], q.cur.col[1:0] + q.beat[1:0]};
    end
    else
    begin
      beat_col = {q.cur.col[3], q.cur.col[2:0] + q.beat};
    end
  end

  // Slot built from a write command on the bus
  always_comb
  begin
    slot.v = 1'b1;
    slot.start = edge_idx + {4'h0, q.write_latency};
    slot.chop = (q.burst_length_field == dwps_pkg::BF_BC4) ||
                ((q.burst_length_field == dwps_pkg::BF_OTF) &&
                 !sy_addr[dwps_pkg::CHOP_SEL_BIT]);
    slot.bank = sy_ba;
    slot.col = sy_addr[3:0];
  end

  // Next-state logic: bus slave first, link second so hardware sets win
  always_comb
  begin
    n = q;
    mem_we = 1'b0;
    mem_idx = {q.cur.bank, beat_col};
    mem_wdata = sy_dq;
    n.dll_reset = 1'b0;
    // Write address and data taken in either order
    if (s_axi_awvalid && !q.aw_have)
    begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_have)
    begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    // Both halves held: perform the write and answer
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = dwps_pkg::RESP_OKAY;
      case (q.aw_addr)
        dwps_pkg::REG_CTRL:
        begin
          if (q.w_strb[0])
          begin
            n.burst_length_field = q.w_data[dwps_pkg::CTRL_BURST_LSB +: 2];
            n.write_latency = q.w_data[dwps_pkg::CTRL_WLAT_LSB +: 4];
          end
        end
        dwps_pkg::REG_STAT:
        begin
          // Error flags clear by writing one
          if (q.w_strb[1] && q.w_data[dwps_pkg::ST_ERR_IDLE])
          begin
            n.err_idle = 1'b0;
          end
          if (q.w_strb[1] && q.w_data[dwps_pkg::ST_ERR_OVF])
          begin
            n.err_ovf = 1'b0;
          end
        end
        dwps_pkg::REG_PTR:
        begin
          if (q.w_strb[0])
          begin
            n.mem_ptr = q.w_data[6:0];
          end
        end
        dwps_pkg::REG_REFC, dwps_pkg::REG_DATA: ; // Read-only, write ignored
        default: n.bresp = dwps_pkg::RESP_SLVERR; // Unmapped
      endcase
    end
    // Read channel: one outstanding answer
    if (q.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid)
    begin
      n.rvalid = 1'b1;
      n.rdata = rd_word;
      n.rresp = dwps_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dwps_pkg::REG_CTRL, dwps_pkg::REG_STAT, dwps_pkg::REG_REFC,
        dwps_pkg::REG_PTR, dwps_pkg::REG_DATA: ;
        default: n.rresp = dwps_pkg::RESP_SLVERR;
      endcase
    end

    // Link edge trackers
    n.ck_prev = sy_ck;
    n.dqs_prev = sy_dqs;
    if (ck_rise)
    begin
      n.ck_cnt = edge_idx;
    end
    if (start_hit)
    begin
      n.cur_run = 1'b1;
    end
    // Data beats: first on a rising strobe, then every strobe edge;
    // the preamble's falling edge comes before the window opens
    if (run_now && q.cur.v && (dqs_rise || (dqs_fall && q.beat != 3'h0)))
    begin
      mem_we = ~sy_dm;
      n.beat = q.beat + 3'h1;
      if (q.beat == (q.cur.chop ? 3'h3 : 3'h7))
      begin
        // Burst done: a concatenated write moves up
        n.cur = q.nxt;
        n.nxt.v = 1'b0;
        n.cur_run = 1'b0;
        n.beat = 3'h0;
      end
    end
    // Exit delays count link clock edges after exit
    if (ck_rise && !q.self_ref && q.exit_cnt < XSDLL_CK)
    begin
      n.exit_cnt = q.exit_cnt + 10'h001;
    end
    // Periodic internal refresh; system clock, as the link clock may stop
    if (q.self_ref)
    begin
      if (q.ref_timer == 10'(dwps_pkg::REF_INT_CYC - 1))
      begin
        n.ref_timer = 10'h000;
        n.ref_cnt = q.ref_cnt + 16'h0001;
      end
      else
      begin
        n.ref_timer = q.ref_timer + 10'h001;
      end
    end
    // Command decode on each rising link clock edge
    if (ck_rise)
    begin
      if (q.self_ref)
      begin
        // Only clock enable is watched here
        if (sy_cke)
        begin
          n.self_ref = 1'b0;
          n.dll_on = 1'b1;
          n.dll_reset = 1'b1;
          n.exit_cnt = 10'h000;
        end
      end
      else if (!sy_cs_n)
      begin
        if (!sy_cke)
        begin
          // Refresh with enable low enters; other low-enable commands ignored
          if (sy_cmd == dwps_pkg::CMD_REF)
          begin
            n.self_ref = 1'b1;
            n.dll_on = 1'b0;
            n.ref_cnt = q.ref_cnt + 16'h0001;
            n.ref_timer = 10'h000;
          end
        end
        else
        begin
          case (sy_cmd)
            dwps_pkg::CMD_MRS:
            begin
              if (sy_ba == 3'h0)
              begin
                n.burst_length_field = sy_addr[1:0];
              end
            end
            dwps_pkg::CMD_REF: n.ref_cnt = q.ref_cnt + 16'h0001;
            dwps_pkg::CMD_PRE:
            begin
              if (sy_addr[dwps_pkg::PRE_ALL_BIT])
              begin
                n.bank_open = 8'h00;
              end
              else
              begin
                n.bank_open[sy_ba] = 1'b0;
              end
            end
            dwps_pkg::CMD_ACT: n.bank_open[sy_ba] = 1'b1;
            dwps_pkg::CMD_WR:
            begin
              if (!q.bank_open[sy_ba])
              begin
                n.err_idle = 1'b1;
              end
              else if (!n.cur.v)
              begin
                n.cur = slot;
              end
              else if (!n.nxt.v)
              begin
                n.nxt = slot;
              end
              else
              begin
                n.err_ovf = 1'b1;
              end
            end
            default: ; // Read, no-op and others need no action here
          endcase
        end
      end
    end
    // Device reset pin clears the memory-side state
    if (!sy_rst_n)
    begin
      n.bank_open = 8'h00;
      n.self_ref = 1'b0;
      n.dll_on = 1'b1;
      n.dll_reset = 1'b0;
      n.exit_cnt = XSDLL_CK;
      n.cur = '0;
      n.nxt = '0;
      n.cur_run = 1'b0;
      n.beat = 3'h0;
      n.burst_length_field = dwps_pkg::BURST_RST;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.burst_length_field <= dwps_pkg::BURST_RST;
      q.write_latency <= dwps_pkg::WLAT_RST;
      q.dll_on <= 1'b1;
      q.exit_cnt <= XSDLL_CK;
    end
    else
    begin
      q <= n;
    end
  end

  // Byte array; no reset, contents are undefined until written
  always_ff @(posedge clk)
  begin
    if (mem_we)
    begin
      mem_q[mem_idx] <= mem_wdata;
    end
  end

  // Bus outputs
  assign s_axi_awready = ~q.aw_have;
  assign s_axi_wready = ~q.w_have;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
endmodule
